// [logic/bsiop_pkg.sv]
// package for the shared bus / general purpose ports e and f
// assumes: registers reached by word index, byte address = 4 * index
package bsiop_pkg;

    // avalon byte address width (index 0xFFAC * 4 needs 18 bits)
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 32;

    // register indices, low 16 bits of the printed address
    localparam logic [15:0] IDX_PE_DIR    = 16'hFEBD;
    localparam logic [15:0] IDX_PF_DIR    = 16'hFEBE;
    localparam logic [15:0] IDX_SYS_CTRL  = 16'hFF39;
    localparam logic [15:0] IDX_PE_LEVEL  = 16'hFF5D;
    localparam logic [15:0] IDX_PF_LEVEL  = 16'hFF5E;
    localparam logic [15:0] IDX_PE_LATCH  = 16'hFF6D;
    localparam logic [15:0] IDX_PF_LATCH  = 16'hFF6E;
    localparam logic [15:0] IDX_PE_PULLUP = 16'hFF74;
    localparam logic [15:0] IDX_PIN_FUNC2 = 16'hFFAC;

    // reset values
    localparam logic [7:0] RST_PE_DIR      = 8'h00;
    localparam logic [7:0] RST_PE_LATCH    = 8'h00;
    localparam logic [7:0] RST_PE_PULLUP   = 8'h00;
    localparam logic [7:0] RST_PF_DIR_BUS  = 8'h80;
    localparam logic [7:0] RST_PF_DIR_SC   = 8'h00;
    localparam logic [7:0] RST_PF_LATCH    = 8'h00;
    localparam logic [7:0] RST_SYS_CTRL    = 8'h01;
    localparam logic [7:0] RST_PIN_FUNC2   = 8'h30;

    // writable bit masks (reserved bits stay zero)
    localparam logic [7:0] MASK_SYS_CTRL   = 8'hBF;
    localparam logic [7:0] MASK_PIN_FUNC2  = 8'hF8;

    // pin_function_ctrl2 fields
    localparam int unsigned PF2_WAIT_SEL   = 7;
    localparam int unsigned PF2_BUS_REQ_OUT_SEL  = 6;
    localparam int unsigned PF2_CS167_EN   = 5;
    localparam int unsigned PF2_CS25_EN    = 4;
    localparam int unsigned PF2_AS_DIS     = 3;

    // system_ctrl field: lower write strobe disable
    localparam int unsigned SYS_LWR_DIS    = 2;

    // port f pin positions
    localparam int unsigned PF_CLK  = 7;
    localparam int unsigned PF_AS   = 6;
    localparam int unsigned PF_RD   = 5;
    localparam int unsigned PF_HWR  = 4;
    localparam int unsigned PF_LWR  = 3;
    localparam int unsigned PF_REQO = 2;
    localparam int unsigned PF_BACK = 1;
    localparam int unsigned PF_BUS_REQ_IN = 0;

    // operating modes
    localparam logic [2:0] MODE_FIRST_EXT = 3'h4;
    localparam logic [2:0] MODE_LAST_EXT  = 3'h6;
    localparam logic [2:0] MODE_SINGLE    = 3'h7;

    // bus slave phase
    typedef enum logic {BSIOP_IDLE, BSIOP_ANSWER} bsiop_phase_t;

endpackage

// [logic/bsiop_ports_e_f.sv]
// ports e and f: general i/o sharing pins with the external bus
// assumes: one clock, avalon-mm slave, standby levels and mode from same clock
//
// Behaviour
// - direction registers cannot be read back
// - port e registers clear on reset, hardware standby
// - modes 4-6, 8-bit bus: port e gpio
// - modes 4-6, 16-bit bus: port e bus data
// - mode 7: port e gpio per direction bit
// - level read: latch if output, else pin
// - pin level registers ignore writes
// - pull-up on when gpio input and enabled
// - pull-ups off in reset, hardware standby
// - port f direction resets to 80/00 by mode
// - port f latch clears on reset, hardware standby
// - port f carries strobes, request, grant, clock
// - software standby: bus outputs hold or float
// - bit 7 selects wait input pin
// - bit 6 routes request output pin
// - bit 5 enables chip selects 1,6,7
// - bit 4 enables chip selects 2-5
// - bit 3 disables address strobe, modes 4-6
// - strobe disabled: pin 6 becomes gpio
// - pin 7: input or system clock out
`timescale 1ns/1ps
module bsiop_ports_e_f
    import bsiop_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [DATA_W-1:0] writedata,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    // chip state
    input  wire logic [2:0]        op_mode,
    input  wire logic              bus_16bit,
    input  wire logic              hw_standby,
    input  wire logic              sw_standby,
    input  wire logic              standby_out_hold,
    input  wire logic              bus_req_out_enable,
    input  wire logic              bus_release_enable,
    input  wire logic              dram_low_col_sel,
    // bus controller side
    input  wire logic [7:0]        bus_data_hi_out,
    input  wire logic              bus_data_hi_oe,
    output logic      [7:0]        bus_data_hi_in,
    input  wire logic              addr_strobe_out_n,
    input  wire logic              read_strobe_n,
    input  wire logic              upper_write_strobe_n,
    input  wire logic              lower_write_strobe_n,
    input  wire logic              dram_low_col_strobe_n,
    input  wire logic              bus_req_out_n,
    input  wire logic              bus_ack_n,
    input  wire logic              sys_clock_src,
    output logic                   bus_req_in_n,
    // function selects to other ports
    output logic                   wait_in_pin_sel,
    output logic                   bus_req_out_on_p53,
    output logic                   chip_sel_1_6_7_enable,
    output logic                   chip_sel_2_to_5_enable,
    // port e pins
    input  wire logic [7:0]        pe_pin_in,
    output logic      [7:0]        pe_pin_out,
    output logic      [7:0]        pe_pin_oe,
    output logic      [7:0]        pe_pullup_on,
    // port f pins
    input  wire logic [7:0]        pf_pin_in,
    output logic      [7:0]        pf_pin_out,
    output logic      [7:0]        pf_pin_oe
);

    // ---------------- registers ----------------
    logic [7:0]   port_e_direction;    // write-only
    logic [7:0]   port_e_output_latch;
    logic [7:0]   port_e_pullup_ctrl;
    logic [7:0]   port_f_direction;    // write-only, mode-dependent reset
    logic [7:0]   port_f_output_latch;
    logic [7:0]   system_ctrl;
    logic [7:0]   pin_function_ctrl2;
    logic         dir_init_pending;    // load port f direction after release
    bsiop_phase_t phase;               // bus slave answer phase

    // ---------------- pin synchronisers ----------------
    logic [15:0] pin_s1;   // first stage, read only by pin_s2
    logic [15:0] pin_s2;
    logic [15:0] pin_s3;
    logic [15:0] pin_lvl;  // accepted level
    logic [15:0] next_pin_lvl;
    wire  [15:0] pin_raw = {pf_pin_in, pe_pin_in};

    // a change counts only once stages two and three agree
    assign next_pin_lvl = (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_lvl & (pin_s2 ^ pin_s3));

    // three-stage synchroniser with agreement filter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1  <= 16'h0000;
            pin_s2  <= 16'h0000;
            pin_s3  <= 16'h0000;
            pin_lvl <= 16'h0000;
        end else begin
            pin_s1  <= pin_raw;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_lvl <= next_pin_lvl;
        end
    end

    wire [7:0] pe_lvl = pin_lvl[7:0];   // filtered port e pins
    wire [7:0] pf_lvl = pin_lvl[15:8];  // filtered port f pins

    // ---------------- mode decode ----------------
    wire mode_ext    = (op_mode >= MODE_FIRST_EXT) && (op_mode <= MODE_LAST_EXT);
    wire mode_single = (op_mode == MODE_SINGLE);
    wire pe_gpio     = (mode_ext && !bus_16bit) || mode_single;
    wire pe_bus      = mode_ext && bus_16bit;

    // ---------------- avalon decode ----------------
    wire        req       = read || write;
    wire        aligned   = (address[1:0] == 2'b00);
    wire [15:0] idx       = address[17:2];
    wire        hit_pe_d  = aligned && (idx == IDX_PE_DIR);
    wire        hit_pf_d  = aligned && (idx == IDX_PF_DIR);
    wire        hit_sys   = aligned && (idx == IDX_SYS_CTRL);
    wire        hit_pe_v  = aligned && (idx == IDX_PE_LEVEL);
    wire        hit_pf_v  = aligned && (idx == IDX_PF_LEVEL);
    wire        hit_pe_l  = aligned && (idx == IDX_PE_LATCH);
    wire        hit_pf_l  = aligned && (idx == IDX_PF_LATCH);
    wire        hit_pe_p  = aligned && (idx == IDX_PE_PULLUP);
    wire        hit_pf2   = aligned && (idx == IDX_PIN_FUNC2);
    // a write lands only in the answer cycle, when waitrequest is low
    wire        wr_go     = write && (phase == BSIOP_ANSWER);
    wire [7:0]  wbyte     = writedata[7:0];

    // level readback: output bits show the latch, inputs the pin
    wire [7:0] pe_level_view = (port_e_direction & port_e_output_latch)
                             | (~port_e_direction & pe_lvl);
    wire [7:0] pf_level_view = (port_f_direction & port_f_output_latch)
                             | (~port_f_direction & pf_lvl);

    // read mux; direction, unmapped and reserved give zero
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit_pe_v)      rd_byte = pe_level_view;
        else if (hit_pf_v) rd_byte = pf_level_view;
        else if (hit_pe_l) rd_byte = port_e_output_latch;
        else if (hit_pf_l) rd_byte = port_f_output_latch;
        else if (hit_pe_p) rd_byte = port_e_pullup_ctrl;
        else if (hit_sys)  rd_byte = system_ctrl;
        else if (hit_pf2)  rd_byte = pin_function_ctrl2;
    end

    // one wait cycle on every access so read data come from a flop
    assign waitrequest = req && (phase == BSIOP_IDLE);

    // bus slave phase and read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase    <= BSIOP_IDLE;
            readdata <= 32'h0000_0000;
        end else begin
            case (phase)
                BSIOP_IDLE: begin
                    if (req) begin
                        phase    <= BSIOP_ANSWER;
                        readdata <= {24'h00_0000, read ? rd_byte : 8'h00};
                    end
                end
                BSIOP_ANSWER: begin
                    phase <= BSIOP_IDLE;   // request released after this edge
                end
                default: begin
                    phase <= BSIOP_IDLE;
                end
            endcase
        end
    end

    // ---------------- port e registers ----------------
    // hardware standby clears; software standby just holds (no writes)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_e_direction    <= RST_PE_DIR;
            port_e_output_latch <= RST_PE_LATCH;
            port_e_pullup_ctrl  <= RST_PE_PULLUP;
        end else if (hw_standby) begin
            port_e_direction    <= RST_PE_DIR;
            port_e_output_latch <= RST_PE_LATCH;
            port_e_pullup_ctrl  <= RST_PE_PULLUP;
        end else if (wr_go) begin
            if (hit_pe_d) port_e_direction    <= wbyte;
            if (hit_pe_l) port_e_output_latch <= wbyte;
            if (hit_pe_p) port_e_pullup_ctrl  <= wbyte;
            // level register writes fall through here untouched
        end
    end

    // ---------------- port f and control registers ----------------
    // direction reset depends on the mode strap, so it is loaded at release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_f_direction    <= RST_PF_DIR_SC;
            port_f_output_latch <= RST_PF_LATCH;
            system_ctrl         <= RST_SYS_CTRL;
            pin_function_ctrl2  <= RST_PIN_FUNC2;
            dir_init_pending    <= 1'b1;
        end else if (hw_standby || dir_init_pending) begin
            port_f_direction    <= mode_single ? RST_PF_DIR_SC : RST_PF_DIR_BUS;
            port_f_output_latch <= RST_PF_LATCH;
            system_ctrl         <= RST_SYS_CTRL;
            pin_function_ctrl2  <= RST_PIN_FUNC2;
            dir_init_pending    <= 1'b0;
        end else if (wr_go) begin
            if (hit_pf_d) port_f_direction    <= wbyte;
            if (hit_pf_l) port_f_output_latch <= wbyte;
            if (hit_sys)  system_ctrl         <= wbyte & MASK_SYS_CTRL;
            if (hit_pf2)  pin_function_ctrl2  <= wbyte & MASK_PIN_FUNC2;
        end
    end

    // ---------------- function selects ----------------
    wire as_disable  = pin_function_ctrl2[PF2_AS_DIS];
    wire lwr_disable = system_ctrl[SYS_LWR_DIS];
    wire bus_req_out_sel   = pin_function_ctrl2[PF2_BUS_REQ_OUT_SEL];

    assign wait_in_pin_sel        = pin_function_ctrl2[PF2_WAIT_SEL];
    // software sets the select before the enable, so no glitch here
    assign bus_req_out_on_p53     = mode_ext && bus_req_out_enable && bus_req_out_sel;
    assign chip_sel_1_6_7_enable  = pin_function_ctrl2[PF2_CS167_EN];
    assign chip_sel_2_to_5_enable = pin_function_ctrl2[PF2_CS25_EN];

    // ---------------- port e pins ----------------
    wire [7:0] pe_oe_live = pe_gpio ? port_e_direction
                          : (pe_bus ? {8{bus_data_hi_oe}} : 8'h00);
    wire [7:0] pe_out_live = pe_gpio ? port_e_output_latch : bus_data_hi_out;

    assign pe_pin_oe      = pe_oe_live;
    assign bus_data_hi_in = pe_lvl;
    // pull-up only on inputs in gpio modes, never in hardware standby
    assign pe_pullup_on   = (pe_gpio && !hw_standby) ?
                            (~port_e_direction & port_e_pullup_ctrl) : 8'h00;

    // port e data from flops: latch or a registered copy of bus data
    logic [7:0] pe_out_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pe_out_q <= 8'h00;
        end else begin
            pe_out_q <= pe_out_live;
        end
    end
    assign pe_pin_out = pe_gpio ? port_e_output_latch : pe_out_q;

    // ---------------- port f pins ----------------
    // which pins carry a bus function, and what they drive
    logic [7:0] pf_bus_fn;   // pin taken by bus function
    logic [7:0] pf_bus_oe;   // enable while in bus function
    logic [7:0] pf_bus_val;  // level while in bus function
    always_comb begin
        pf_bus_fn  = 8'h00;
        pf_bus_oe  = 8'h00;
        pf_bus_val = 8'hFF;
        // address strobe unless disabled, only in external modes
        pf_bus_fn[PF_AS]   = mode_ext && !as_disable;
        pf_bus_oe[PF_AS]   = 1'b1;
        pf_bus_val[PF_AS]  = addr_strobe_out_n;
        // read and upper write strobes always in external modes
        pf_bus_fn[PF_RD]   = mode_ext;
        pf_bus_oe[PF_RD]   = 1'b1;
        pf_bus_val[PF_RD]  = read_strobe_n;
        pf_bus_fn[PF_HWR]  = mode_ext;
        pf_bus_oe[PF_HWR]  = 1'b1;
        pf_bus_val[PF_HWR] = upper_write_strobe_n;
        // lower write strobe, switchable
        pf_bus_fn[PF_LWR]  = mode_ext && !lwr_disable;
        pf_bus_oe[PF_LWR]  = 1'b1;
        pf_bus_val[PF_LWR] = lower_write_strobe_n;
        // dram column strobe wins over request out
        if (mode_ext && dram_low_col_sel) begin
            pf_bus_fn[PF_REQO]  = 1'b1;
            pf_bus_oe[PF_REQO]  = 1'b1;
            pf_bus_val[PF_REQO] = dram_low_col_strobe_n;
        end else if (mode_ext && bus_req_out_enable && !bus_req_out_sel) begin
            pf_bus_fn[PF_REQO]  = 1'b1;
            pf_bus_oe[PF_REQO]  = 1'b1;
            pf_bus_val[PF_REQO] = bus_req_out_n;
        end
        // bus grant out, bus request in
        pf_bus_fn[PF_BACK]  = mode_ext && bus_release_enable;
        pf_bus_oe[PF_BACK]  = 1'b1;
        pf_bus_val[PF_BACK] = bus_ack_n;
        pf_bus_fn[PF_BUS_REQ_IN]  = mode_ext && bus_release_enable;  // input only
    end

    // software standby: freeze or float the bus control outputs
    logic [7:0] held_out;  // last live levels before standby
    logic [7:0] held_oe;
    wire  [7:0] pf_oe_live  = (pf_bus_fn & pf_bus_oe) | (~pf_bus_fn & port_f_direction);
    wire  [7:0] pf_out_live = (pf_bus_fn & pf_bus_val) | (~pf_bus_fn & port_f_output_latch);
    wire  [7:0] sb_mask     = sw_standby ? (pf_bus_fn & pf_bus_oe) : 8'h00;

    // capture while running, so the frozen state is the pre-standby one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held_out <= 8'hFF;
            held_oe  <= 8'h00;
        end else if (!sw_standby) begin
            held_out <= pf_out_live;
            held_oe  <= pf_oe_live;
        end
    end

    logic [7:0] pf_oe_mix;
    logic [7:0] pf_out_mix;
    always_comb begin
        pf_oe_mix  = pf_oe_live;
        pf_out_mix = pf_out_live;
        if (standby_out_hold) begin
            pf_oe_mix  = (sb_mask & held_oe)  | (~sb_mask & pf_oe_live);
            pf_out_mix = (sb_mask & held_out) | (~sb_mask & pf_out_live);
        end else begin
            pf_oe_mix  = ~sb_mask & pf_oe_live;
        end
        // pin 7: clock out when its direction bit is set, else input
        pf_oe_mix[PF_CLK]  = port_f_direction[PF_CLK];
        pf_out_mix[PF_CLK] = sys_clock_src;
    end

    assign pf_pin_oe    = pf_oe_mix;
    assign pf_pin_out   = pf_out_mix;
    assign bus_req_in_n = pf_bus_fn[PF_BUS_REQ_IN] ? pf_lvl[PF_BUS_REQ_IN] : 1'b1;

    // ---------------- checks ----------------
    sequence s_read_done(logic hit);
        read && hit && !waitrequest;
    endsequence
    sequence s_standby_float;
        sw_standby && !standby_out_hold && pf_bus_fn[PF_AS];
    endsequence

    chk_dir_read_zero: assert property (
        @(posedge clk) disable iff (rst)
        s_read_done(hit_pe_d || hit_pf_d) |-> readdata == 32'h0000_0000)
        else $error("direction register read back non-zero");
    chk_pe_standby_clear: assert property (
        @(posedge clk) disable iff (rst)
        hw_standby |=> port_e_direction == 8'h00 && port_e_output_latch == 8'h00
                       && port_e_pullup_ctrl == 8'h00)
        else $error("port e registers not cleared by hardware standby");
    chk_pe_gpio_dir: assert property (
        @(posedge clk) disable iff (rst)
        pe_gpio |-> pe_pin_oe == port_e_direction && pe_pin_out == port_e_output_latch)
        else $error("port e gpio drive does not follow direction and latch");
    chk_pe_bus_data: assert property (
        @(posedge clk) disable iff (rst)
        pe_bus ##1 pe_bus |-> pe_pin_oe == {8{bus_data_hi_oe}} && pe_pin_out == $past(bus_data_hi_out))
        else $error("port e does not carry upper bus data");
    chk_pe_level_read: assert property (
        @(posedge clk) disable iff (rst)
        (read && hit_pe_v && waitrequest && !hw_standby) ##1 s_read_done(hit_pe_v)
        |-> readdata[7:0] == (($past(port_e_direction) & $past(port_e_output_latch))
                              | (~$past(port_e_direction) & $past(pe_lvl))))
        else $error("port e level read wrong");
    chk_level_no_write: assert property (
        @(posedge clk) disable iff (rst)
        (write && (hit_pe_v || hit_pf_v) && !waitrequest && !hw_standby && !dir_init_pending)
        |=> $stable(port_e_output_latch) && $stable(port_f_output_latch))
        else $error("pin level write changed a latch");
    chk_pullup_gate: assert property (
        @(posedge clk) disable iff (rst)
        (pe_pullup_on != 8'h00) |-> pe_gpio && !hw_standby
            && (pe_pullup_on & port_e_direction) == 8'h00)
        else $error("pull-up on for an output or outside gpio modes");
    chk_pf_dir_init: assert property (
        @(posedge clk) disable iff (rst)
        hw_standby |=> port_f_direction == ($past(mode_single) ? RST_PF_DIR_SC : RST_PF_DIR_BUS))
        else $error("port f direction wrong after hardware standby");
    chk_standby_float: assert property (
        @(posedge clk) disable iff (rst)
        s_standby_float |-> !pf_pin_oe[PF_AS])
        else $error("address strobe pin driven in floating standby");
    chk_reqo_route: assert property (
        @(posedge clk) disable iff (rst)
        mode_ext && bus_req_out_enable && !dram_low_col_sel && !bus_req_out_sel
        |-> pf_pin_out[PF_REQO] == bus_req_out_n && !bus_req_out_on_p53)
        else $error("request out not on port f pin 2");
    chk_clock_pin: assert property (
        @(posedge clk) disable iff (rst)
        pf_pin_oe[PF_CLK] == port_f_direction[PF_CLK])
        else $error("clock pin enable does not follow its direction bit");
endmodule

// [tb/bsiop_board.sv]
// board model for one 8-bit port: resolves each pin from all drivers
// assumes: design oe high while driving; board drives only where enabled
`timescale 1ns/1ps
module bsiop_board (
    // clock
    input  wire logic       clk,
    // design side of the pins
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_on,
    // board side drivers
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    // resolved pin levels
    output logic      [7:0] pin_lvl
);
    logic [7:0] float_pat = 8'hA5; // undriven lines wander, never a settled guess
    // floating pattern flips every cycle
    always_ff @(posedge clk) begin
        float_pat <= ~float_pat;
    end
    // design first, then board, then pull-up, else floating
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                   | (~pin_oe & ~ext_en & (pullup_on | float_pat));
endmodule

// [tb/bsiop_ports_e_f_tb.sv]
// self-checking bench for ports e and f
// assumes: avalon slave answers after one wait cycle, pins filtered 3-4 clocks
`timescale 1ns/1ps
module bsiop_ports_e_f_tb
    import bsiop_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, b16 = 1'b0, hws = 1'b0;
    logic bus_req_in_en = 1'b0, hi_oe = 1'b0, phi = 1'b1, sws = 1'b0, brle = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic [DATA_W-1:0] writedata = '0, readdata;
    logic [2:0] op_mode = 3'h7;
    logic [7:0] strb = 8'hFF, hi_out = 8'h00, pe_ext = 8'h00, pe_en = 8'h00, pf_ext = 8'h00, pf_en = 8'h00;
    logic [7:0] rq, hi_in, pe_in, pe_out, pe_oe, pe_pu, pf_in, pf_out, pf_oe;
    logic waitrequest, bus_req_in_in_n, wsel, p53, cs167, cs25;
    int n_errors = 0, num_checks = 0;
    // ordinary cases: {index, expected reset value}, then {index, write, readback}
    logic [23:0] rst_rows [7] = '{24'hFF6D00, 24'hFF6E00, 24'hFF7400, 24'hFF3901, 24'hFFAC30,
                                  24'hFEBD00, 24'hFEBE00};
    logic [31:0] wr_rows [5] = '{32'hFF6D5A5A, 32'hFFACFFF8, 32'hFF39FFBF, 32'hFEBDFF00, 32'hFEBEFF00};

    // clock: 50 ns period
    always #25 clk = ~clk;

    bsiop_ports_e_f dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .op_mode(op_mode),
        .bus_16bit(b16), .hw_standby(hws), .sw_standby(sws), .standby_out_hold(strb[7]),
        .bus_req_out_enable(bus_req_in_en), .bus_release_enable(brle), .dram_low_col_sel(1'b0),
        .bus_data_hi_out(hi_out), .bus_data_hi_oe(hi_oe), .bus_data_hi_in(hi_in),
        .addr_strobe_out_n(strb[0]), .read_strobe_n(strb[1]), .upper_write_strobe_n(strb[2]),
        .lower_write_strobe_n(strb[3]), .dram_low_col_strobe_n(strb[4]), .bus_req_out_n(strb[5]),
        .bus_ack_n(strb[6]), .sys_clock_src(phi), .bus_req_in_n(bus_req_in_in_n), .wait_in_pin_sel(wsel),
        .bus_req_out_on_p53(p53), .chip_sel_1_6_7_enable(cs167), .chip_sel_2_to_5_enable(cs25),
        .pe_pin_in(pe_in), .pe_pin_out(pe_out), .pe_pin_oe(pe_oe), .pe_pullup_on(pe_pu),
        .pf_pin_in(pf_in), .pf_pin_out(pf_out), .pf_pin_oe(pf_oe));
    bsiop_board brd_e (.clk(clk), .pin_out(pe_out), .pin_oe(pe_oe), .pullup_on(pe_pu),
        .ext_val(pe_ext), .ext_en(pe_en), .pin_lvl(pe_in));
    bsiop_board brd_f (.clk(clk), .pin_out(pf_out), .pin_oe(pf_oe), .pullup_on(8'h00),
        .ext_val(pf_ext), .ext_en(pf_en), .pin_lvl(pf_in));

    // verdict and end of run
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one avalon access, held until waitrequest samples low
    task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] d);
        address <= {idx, 2'b00};
        writedata <= {24'h000000, d};
        read <= ~w;
        write <= w;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rq = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    // read and compare
    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
        acc(1'b0, idx, 8'h00);
        chk(rq, exp);
    endtask
    // wait a few clocks for pins and filters
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask

    // watchdog: whole sequence needs under two hundred clocks
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(pe_pu, 8'h00);
        chk(pf_oe, 8'h00);
        foreach (rst_rows[i]) rdc(rst_rows[i][23:8], rst_rows[i][7:0]);
        foreach (wr_rows[i]) begin
            acc(1'b1, wr_rows[i][31:16], wr_rows[i][15:8]);
            rdc(wr_rows[i][31:16], wr_rows[i][7:0]);
        end
        chk({5'h00, wsel, cs167, cs25}, 8'h07);
        // mode 7 gpio: port e upper pins driven, lower read from board; port f the reverse
        pe_ext <= 8'h3C;
        pe_en <= 8'h0F;
        pf_ext <= 8'h3C;
        pf_en <= 8'hF0;
        acc(1'b1, IDX_PE_DIR, 8'hF0);
        acc(1'b1, IDX_PE_PULLUP, 8'hFF);
        acc(1'b1, IDX_PF_LATCH, 8'hA5);
        acc(1'b1, IDX_PF_DIR, 8'h0F);
        settle();
        chk(pe_oe, 8'hF0);
        chk(pe_pu, 8'h0F);
        rdc(IDX_PE_LEVEL, 8'h5C);
        rdc(IDX_PF_LEVEL, 8'h35);
        acc(1'b1, IDX_PE_LEVEL, 8'h00);
        rdc(IDX_PE_LEVEL, 8'h5C);
        // mode 4: 8-bit bus keeps gpio, 16-bit bus takes the port
        op_mode <= 3'h4;
        hi_out <= 8'hC3;
        hi_oe <= 1'b1;
        settle();
        chk(pe_oe, 8'hF0);
        b16 <= 1'b1;
        settle();
        chk(pe_oe, 8'hFF);
        chk(pe_out, 8'hC3);
        chk(hi_in, 8'hC3);
        chk(pe_pu, 8'h00);
        // request-out pin select programmed before the enable
        acc(1'b1, IDX_PIN_FUNC2, 8'h40);
        bus_req_in_en <= 1'b1;
        settle();
        chk({7'h00, p53}, 8'h01);
        chk({5'h00, wsel, cs167, cs25}, 8'h00);
        // hardware standby reloads port f direction by mode
        hws <= 1'b1;
        repeat (2) @(posedge clk);
        hws <= 1'b0;
        settle();
        chk(pf_oe, 8'hFC);
        chk({7'h00, pf_out[PF_CLK]}, 8'h01);
        phi <= 1'b0;
        @(posedge clk);
        chk({7'h00, pf_out[PF_CLK]}, 8'h00);
        chk({5'h00, wsel, cs167, cs25}, 8'h03);
        rdc(IDX_PE_LATCH, 8'h00);
        rdc(IDX_PF_LATCH, 8'h00);
        // software standby: strobe low before entry must stay frozen, then float
        strb[0] <= 1'b0;
        @(posedge clk);
        sws <= 1'b1;
        @(posedge clk);
        strb[0] <= 1'b1;
        settle();
        chk({6'h00, pf_oe[PF_AS], pf_out[PF_AS]}, 8'h02);
        strb[7] <= 1'b0;
        settle();
        chk(pf_oe, 8'h80);
        sws <= 1'b0;
        strb[7] <= 1'b1;
        settle();
        chk(pf_oe, 8'hFC);
        acc(1'b1, IDX_PIN_FUNC2, 8'h48);
        settle();
        chk(pf_oe, 8'hB8);
        // bus release: grant out on pin 1, request in read from pin 0
        pf_en <= 8'hF1;
        brle <= 1'b1;
        settle();
        chk({7'h00, bus_req_in_in_n}, 8'h00);
        chk(pf_oe, 8'hBA);
        close_out();
    end
endmodule
